//--- src/cpt_pkg.sv
// What this block does
// - input select bits 7:6 pick microphone amp one, two, three, or none
// - output select bits 5:4 pick external amp, earphone one, two, or none
// - amplifiers not selected are powered down and their outputs float
// - bit 3 chooses long (0) or short (1) frame sync
// - bit 1 routes common switch pin to pin A (0) or C (1)
// - gain register bits 7 and 3 gate transmit/receive PCM, 0 means on
// - transmit gain code: -6 dB at 000, 2 dB steps, reset 0 dB
// - receive gain code: -12 dB at 000, 3 dB steps, reset -3 dB
// - transmit gain scales tones from -16 dBm0 low group, -14 otherwise
// - side-tone code 000 off, then -15 dB to -3 dB in 2 dB steps
// - tone gain register bit 4 switches the tone generator on
// - receive tone gain code 0000 mutes, then -34 dB to -6 dB
// - receive tone referenced to +4/+6 dBm0, delivered to external amp
// - tone mode bit 7 selects DTMF (1) or other tones (0)
// - tone mode bit 6 sends generated tone instead of voice
// - other tones: 5-bit code picks from fixed table, gaps undefined
package cpt_pkg;
  localparam int NREG = 4;
  localparam logic [7:0] OFS_PATH = 8'h01;
  localparam logic [7:0] OFS_PCM = 8'h02;
  localparam logic [7:0] OFS_TGAIN = 8'h03;
  localparam logic [7:0] OFS_TMODE = 8'h04;
  localparam logic [7:0] RST_VAL [NREG] = '{8'h00, 8'h33, 8'h00, 8'h00};
  // unused bits are kept at zero so they read back as zero
  localparam logic [7:0] WMASK [NREG] = '{8'hfb, 8'hff, 8'hff, 8'hdf};
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  // field positions
  localparam int IN_HI = 7;
  localparam int IN_LO = 6;
  localparam int OUT_HI = 5;
  localparam int OUT_LO = 4;
  localparam int SHORT_BIT = 3;
  localparam int SW_BIT = 1;
  localparam int PAD_BIT = 0;
  localparam int TXOFF_BIT = 7;
  localparam int TXG_HI = 6;
  localparam int TXG_LO = 4;
  localparam int RXOFF_BIT = 3;
  localparam int RXG_HI = 2;
  localparam int RXG_LO = 0;
  localparam int ST_HI = 7;
  localparam int ST_LO = 5;
  localparam int TONE_ON_BIT = 4;
  localparam int TG_HI = 3;
  localparam int TG_LO = 0;
  localparam int FAMILY_BIT = 7;
  localparam int SEND_BIT = 6;
  localparam int FREQ_HI = 4;
  localparam int FREQ_LO = 0;
  localparam int DLO_HI = 3;
  localparam int DLO_LO = 2;
  localparam int DHI_HI = 1;
  localparam int DHI_LO = 0;
  localparam logic [1:0] SEL_NONE = 2'h3;
  // gain laws in dB and reference levels in dBm0
  localparam int TX_BASE_DB = -6;
  localparam int TX_STEP_DB = 2;
  localparam int RX_BASE_DB = -12;
  localparam int RX_STEP_DB = 3;
  localparam int ST_BASE_DB = -17;
  localparam int ST_STEP_DB = 2;
  localparam int TG_BASE_DB = -36;
  localparam int TG_STEP_DB = 2;
  localparam int PAD_LOSS_DB = 12;
  localparam int TX_REF_LO = -16;
  localparam int TX_REF_HI = -14;
  localparam int RX_REF_LO = 4;
  localparam int RX_REF_HI = 6;
  localparam logic [2:0] BIT_LAST = 3'h7;
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RACK
  } cpt_bus_e;
endpackage

//--- src/cpt_regs.sv
`timescale 1ns/1ps
module cpt_regs #(
  parameter logic [6:0] DEV_ADDR = 7'h2a // arbitrary bus address
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic [2:0] mic_amp_en_o,
  output logic [2:0] out_amp_en_o,
  output logic short_frame_o,
  output logic switch_a_conn_o,
  output logic switch_c_conn_o,
  output logic rx_pad_en_o,
  output logic tx_pcm_en_o,
  output logic rx_pcm_en_o,
  output logic signed [6:0] tx_gain_db_o,
  output logic signed [6:0] rx_gain_db_o,
  output logic sidetone_en_o,
  output logic signed [6:0] sidetone_db_o,
  output logic tone_gen_en_o,
  output logic rx_tone_mute_o,
  output logic signed [6:0] rx_tone_db_o,
  output logic ext_tone_en_o,
  output logic tone_dtmf_o,
  output logic tone_send_o,
  output logic signed [6:0] tx_tone_lvl_a_o,
  output logic signed [6:0] tx_tone_lvl_b_o,
  output logic signed [6:0] rx_tone_lvl_a_o,
  output logic signed [6:0] rx_tone_lvl_b_o,
  output logic [11:0] tone_freq_a_o,
  output logic [11:0] tone_freq_b_o,
  output logic tone_warble_o,
  output logic tone_valid_o
);

  function automatic logic reg_hit(input logic [7:0] p);
    reg_hit = (p >= cpt_pkg::OFS_PATH) && (p <= cpt_pkg::OFS_TMODE);
  endfunction
  function automatic logic [1:0] reg_idx(input logic [7:0] p);
    reg_idx = 2'(p - cpt_pkg::OFS_PATH);
  endfunction
  // one-hot amp enable; the none code leaves every amp off and floating
  function automatic logic [2:0] amp_sel(input logic [1:0] c);
    amp_sel = (c == cpt_pkg::SEL_NONE) ? 3'h0 : 3'(3'h1 << c);
  endfunction
  // {valid, warble, freq a, freq b} for the non-DTMF tone table
  function automatic logic [25:0] other_tone(input logic [4:0] c);
    case (c)
      5'h00: other_tone = {2'h3, 12'haaa, 12'h9c4};
      5'h01: other_tone = {2'h3, 12'h7d0, 12'ha6b};
      5'h02: other_tone = {2'h3, 12'h3e8, 12'h535};
      5'h09: other_tone = {2'h2, 12'h190, 12'h190};
      5'h0a: other_tone = {2'h2, 12'h1b8, 12'h1b8};
      5'h0b: other_tone = {2'h2, 12'h1e0, 12'h1e0};
      5'h0d: other_tone = {2'h2, 12'h29b, 12'h29b};
      5'h0e: other_tone = {2'h2, 12'h320, 12'h320};
      5'h0f: other_tone = {2'h2, 12'h3e8, 12'h3e8};
      5'h10: other_tone = {2'h2, 12'h4b0, 12'h4b0};
      5'h11: other_tone = {2'h2, 12'h514, 12'h514};
      5'h13: other_tone = {2'h2, 12'h5c5, 12'h5c5};
      5'h14: other_tone = {2'h2, 12'h661, 12'h661};
      5'h15: other_tone = {2'h2, 12'h7d0, 12'h7d0};
      5'h16: other_tone = {2'h2, 12'h834, 12'h834};
      5'h18: other_tone = {2'h2, 12'h960, 12'h960};
      5'h1a: other_tone = {2'h2, 12'h9c4, 12'h9c4};
      5'h1d: other_tone = {2'h2, 12'ha8c, 12'ha8c};
      5'h1f: other_tone = {2'h2, 12'hbb8, 12'hbb8};
      default: other_tone = 26'h0; // undefined codes give no tone
    endcase
  endfunction
  // dtmf low group 697/770/852/941 Hz, high group 1209/1336/1477/1633 Hz
  function automatic logic [11:0] dtmf_lo(input logic [1:0] c);
    case (c)
      2'h0: dtmf_lo = 12'h2b9;
      2'h1: dtmf_lo = 12'h302;
      2'h2: dtmf_lo = 12'h354;
      default: dtmf_lo = 12'h3ad;
    endcase
  endfunction
  function automatic logic [11:0] dtmf_hi(input logic [1:0] c);
    case (c)
      2'h0: dtmf_hi = 12'h4b9;
      2'h1: dtmf_hi = 12'h538;
      2'h2: dtmf_hi = 12'h5c5;
      default: dtmf_hi = 12'h661;
    endcase
  endfunction
  // pin synchronisers: index 0 is scl, index 1 is sda
  logic [1:0] pin_in;
  assign pin_in = {sda_i, scl_i};
  for (genvar g = 0; g < 2; g++) begin : g_sync
    logic [2:0] sy_q;
    logic [2:0] sy_d;
    logic flt_q;
    logic flt_d;
    logic prv_q;
    // a level counts only once stages two and three agree, which rejects short glitches
    always_comb begin
      sy_d = {sy_q[1:0], pin_in[g]};
      flt_d = (sy_q[1] == sy_q[2]) ? sy_q[1] : flt_q;
    end
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        sy_q <= '1;
        flt_q <= 1'b1;
        prv_q <= 1'b1;
      end else begin
        sy_q <= sy_d;
        flt_q <= flt_d;
        prv_q <= flt_q;
      end
    end
  end
  // edges come from the filtered level against its copy one clock older
  wire logic scl = g_sync[0].flt_q;
  wire logic scl_p = g_sync[0].prv_q;
  wire logic sda = g_sync[1].flt_q;
  wire logic sda_p = g_sync[1].prv_q;
  wire logic scl_rise = scl & ~scl_p;
  wire logic scl_fall = ~scl & scl_p;
  wire logic bus_start = scl & scl_p & sda_p & ~sda;
  wire logic bus_stop = scl & scl_p & ~sda_p & sda;
  cpt_pkg::cpt_bus_e st_q;
  cpt_pkg::cpt_bus_e st_d;
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic [7:0] sr_q;
  logic [7:0] sr_d;
  logic [7:0] ptr_q;
  logic [7:0] ptr_d;
  logic rw_q;
  logic rw_d;
  logic oe_d;
  logic [7:0] rd;
  logic [7:0] regs_q [cpt_pkg::NREG];
  logic [7:0] regs_d [cpt_pkg::NREG];
  // serial slave: bits sampled on scl rise, sda driven after scl fall
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sr_d = sr_q;
    ptr_d = ptr_q;
    rw_d = rw_q;
    oe_d = sda_oe_o;
    regs_d = regs_q;
    rd = reg_hit(ptr_q) ? regs_q[reg_idx(ptr_q)] : cpt_pkg::RD_UNMAPPED;
    if (bus_start) begin
      st_d = cpt_pkg::ST_ADDR;
      cnt_d = 3'h0;
      oe_d = 1'b0;
    end else if (bus_stop) begin
      st_d = cpt_pkg::ST_IDLE;
      oe_d = 1'b0;
    end else if (scl_rise) begin
      case (st_q)
        cpt_pkg::ST_ADDR, cpt_pkg::ST_PTR, cpt_pkg::ST_WDATA: begin
          sr_d = {sr_q[6:0], sda};
          cnt_d = 3'(cnt_q + 3'h1);
          if (cnt_q == cpt_pkg::BIT_LAST) begin
            if (st_q == cpt_pkg::ST_ADDR) begin
              rw_d = sr_d[0];
              st_d = (sr_d[7:1] == DEV_ADDR) ? cpt_pkg::ST_ADDR_ACK : cpt_pkg::ST_IDLE;
            end else if (st_q == cpt_pkg::ST_PTR) begin
              ptr_d = sr_d;
              st_d = cpt_pkg::ST_PTR_ACK;
            end else begin
              // reserved bits are masked off in case the controller leaves them set
              if (reg_hit(ptr_q)) begin
                regs_d[reg_idx(ptr_q)] = sr_d & cpt_pkg::WMASK[reg_idx(ptr_q)];
              end
              ptr_d = 8'(ptr_q + 8'h01);
              st_d = cpt_pkg::ST_WDATA_ACK;
            end
          end
        end
        cpt_pkg::ST_RDATA: begin
          cnt_d = 3'(cnt_q + 3'h1);
          if (cnt_q == cpt_pkg::BIT_LAST) begin
            st_d = cpt_pkg::ST_RACK;
          end
        end
        cpt_pkg::ST_RACK: begin
          if (!sda) begin
            ptr_d = 8'(ptr_q + 8'h01);
            st_d = cpt_pkg::ST_RDATA;
          end else begin
            st_d = cpt_pkg::ST_IDLE;
          end
        end
        default: ;
      endcase
    end else if (scl_fall) begin
      case (st_q)
        cpt_pkg::ST_ADDR_ACK, cpt_pkg::ST_PTR_ACK, cpt_pkg::ST_WDATA_ACK: begin
          if (!sda_oe_o) begin
            oe_d = 1'b1;
          end else if (st_q == cpt_pkg::ST_ADDR_ACK && rw_q) begin
            st_d = cpt_pkg::ST_RDATA;
            oe_d = ~rd[cpt_pkg::BIT_LAST];
          end else begin
            oe_d = 1'b0;
            st_d = (st_q == cpt_pkg::ST_ADDR_ACK) ? cpt_pkg::ST_PTR : cpt_pkg::ST_WDATA;
          end
        end
        cpt_pkg::ST_RDATA: oe_d = ~rd[3'(cpt_pkg::BIT_LAST - cnt_q)];
        cpt_pkg::ST_RACK: oe_d = 1'b0;
        default: ;
      endcase
    end
  end
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= cpt_pkg::ST_IDLE;
      cnt_q <= 3'h0;
      sr_q <= 8'h00;
      ptr_q <= 8'h00;
      rw_q <= 1'b0;
      sda_oe_o <= 1'b0;
      regs_q <= cpt_pkg::RST_VAL;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sr_q <= sr_d;
      ptr_q <= ptr_d;
      rw_q <= rw_d;
      sda_oe_o <= oe_d;
      regs_q <= regs_d;
    end
  end
  // open drain: only ever pull low
  assign sda_o = 1'b0;
  // decoded controls, registered so every output comes from a flip-flop
  logic [7:0] pth;
  logic [7:0] pcm;
  logic [7:0] tgr;
  logic [7:0] tmr;
  logic [25:0] oth;
  logic signed [6:0] txdb_d;
  logic signed [6:0] tgdb_d;
  logic signed [6:0] rxdb_d;
  logic signed [6:0] stdb_d;
  logic signed [6:0] txa_d;
  logic signed [6:0] rxa_d;
  logic [11:0] fa_d;
  logic [11:0] fb_d;
  logic warb_d;
  logic valid_d;
  always_comb begin
    pth = regs_q[reg_idx(cpt_pkg::OFS_PATH)];
    pcm = regs_q[reg_idx(cpt_pkg::OFS_PCM)];
    tgr = regs_q[reg_idx(cpt_pkg::OFS_TGAIN)];
    tmr = regs_q[reg_idx(cpt_pkg::OFS_TMODE)];
    txdb_d = 7'(cpt_pkg::TX_BASE_DB + cpt_pkg::TX_STEP_DB * int'(pcm[cpt_pkg::TXG_HI:cpt_pkg::TXG_LO]));
    // pad loss folded into the reported receive gain
    rxdb_d = 7'(cpt_pkg::RX_BASE_DB + cpt_pkg::RX_STEP_DB * int'(pcm[cpt_pkg::RXG_HI:cpt_pkg::RXG_LO])
      - (pth[cpt_pkg::PAD_BIT] ? cpt_pkg::PAD_LOSS_DB : 0));
    stdb_d = 7'(cpt_pkg::ST_BASE_DB + cpt_pkg::ST_STEP_DB * int'(tgr[cpt_pkg::ST_HI:cpt_pkg::ST_LO]));
    tgdb_d = 7'(cpt_pkg::TG_BASE_DB + cpt_pkg::TG_STEP_DB * int'(tgr[cpt_pkg::TG_HI:cpt_pkg::TG_LO]));
    // level a is the low group for dtmf; other tones use the high-group reference
    txa_d = 7'(int'(txdb_d) + (tmr[cpt_pkg::FAMILY_BIT] ? cpt_pkg::TX_REF_LO : cpt_pkg::TX_REF_HI));
    rxa_d = 7'(int'(tgdb_d) + (tmr[cpt_pkg::FAMILY_BIT] ? cpt_pkg::RX_REF_LO : cpt_pkg::RX_REF_HI));
    oth = other_tone(tmr[cpt_pkg::FREQ_HI:cpt_pkg::FREQ_LO]);
    if (tmr[cpt_pkg::FAMILY_BIT]) begin
      // bit 4 plays no part in dtmf selection
      fa_d = dtmf_lo(tmr[cpt_pkg::DLO_HI:cpt_pkg::DLO_LO]);
      fb_d = dtmf_hi(tmr[cpt_pkg::DHI_HI:cpt_pkg::DHI_LO]);
      warb_d = 1'b0;
      valid_d = 1'b1;
    end else begin
      fa_d = oth[23:12];
      fb_d = oth[11:0];
      warb_d = oth[24];
      valid_d = oth[25];
    end
  end
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mic_amp_en_o <= 3'h0;
      out_amp_en_o <= 3'h0;
      short_frame_o <= 1'b0;
      switch_a_conn_o <= 1'b0;
      switch_c_conn_o <= 1'b0;
      rx_pad_en_o <= 1'b0;
      tx_pcm_en_o <= 1'b0;
      rx_pcm_en_o <= 1'b0;
      tx_gain_db_o <= 7'sh00;
      rx_gain_db_o <= 7'sh00;
      sidetone_en_o <= 1'b0;
      sidetone_db_o <= 7'sh00;
      tone_gen_en_o <= 1'b0;
      rx_tone_mute_o <= 1'b1;
      rx_tone_db_o <= 7'sh00;
      ext_tone_en_o <= 1'b0;
      tone_dtmf_o <= 1'b0;
      tone_send_o <= 1'b0;
      tx_tone_lvl_a_o <= 7'sh00;
      tx_tone_lvl_b_o <= 7'sh00;
      rx_tone_lvl_a_o <= 7'sh00;
      rx_tone_lvl_b_o <= 7'sh00;
      tone_freq_a_o <= 12'h000;
      tone_freq_b_o <= 12'h000;
      tone_warble_o <= 1'b0;
      tone_valid_o <= 1'b0;
    end else begin
      mic_amp_en_o <= amp_sel(pth[cpt_pkg::IN_HI:cpt_pkg::IN_LO]);
      out_amp_en_o <= amp_sel(pth[cpt_pkg::OUT_HI:cpt_pkg::OUT_LO]);
      short_frame_o <= pth[cpt_pkg::SHORT_BIT];
      switch_a_conn_o <= ~pth[cpt_pkg::SW_BIT];
      switch_c_conn_o <= pth[cpt_pkg::SW_BIT];
      rx_pad_en_o <= pth[cpt_pkg::PAD_BIT];
      tx_pcm_en_o <= ~pcm[cpt_pkg::TXOFF_BIT];
      rx_pcm_en_o <= ~pcm[cpt_pkg::RXOFF_BIT];
      tx_gain_db_o <= txdb_d;
      rx_gain_db_o <= rxdb_d;
      sidetone_en_o <= |tgr[cpt_pkg::ST_HI:cpt_pkg::ST_LO];
      sidetone_db_o <= stdb_d;
      tone_gen_en_o <= tgr[cpt_pkg::TONE_ON_BIT];
      rx_tone_mute_o <= ~|tgr[cpt_pkg::TG_HI:cpt_pkg::TG_LO];
      rx_tone_db_o <= tgdb_d;
      ext_tone_en_o <= tgr[cpt_pkg::TONE_ON_BIT] & |tgr[cpt_pkg::TG_HI:cpt_pkg::TG_LO];
      tone_dtmf_o <= tmr[cpt_pkg::FAMILY_BIT];
      tone_send_o <= tmr[cpt_pkg::SEND_BIT];
      tx_tone_lvl_a_o <= txa_d;
      tx_tone_lvl_b_o <= 7'(int'(txdb_d) + cpt_pkg::TX_REF_HI);
      rx_tone_lvl_a_o <= rxa_d;
      rx_tone_lvl_b_o <= 7'(int'(tgdb_d) + cpt_pkg::RX_REF_HI);
      tone_freq_a_o <= fa_d;
      tone_freq_b_o <= fb_d;
      tone_warble_o <= warb_d;
      tone_valid_o <= valid_d;
    end
  end
endmodule // cpt_regs

//--- verif/cpt_regs_assertions.sv
`timescale 1ns/1ps
module cpt_regs_assertions (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic [2:0] mic_amp_en_o,
  input wire logic [2:0] out_amp_en_o,
  input wire logic switch_a_conn_o,
  input wire logic switch_c_conn_o,
  input wire logic signed [6:0] tx_gain_db_o,
  input wire logic sidetone_en_o,
  input wire logic signed [6:0] sidetone_db_o,
  input wire logic tone_gen_en_o,
  input wire logic rx_tone_mute_o,
  input wire logic signed [6:0] rx_tone_db_o,
  input wire logic ext_tone_en_o,
  input wire logic tone_dtmf_o,
  input wire logic tone_send_o,
  input wire logic signed [6:0] tx_tone_lvl_a_o,
  input wire logic signed [6:0] tx_tone_lvl_b_o,
  input wire logic signed [6:0] rx_tone_lvl_a_o,
  input wire logic [11:0] tone_freq_a_o,
  input wire logic [11:0] tone_freq_b_o,
  input wire logic tone_valid_o
);
  logic [1:0] up_q;
  logic [1:0] up_d;
  logic [31:0] cfg;
  // decoded outputs still show zeros for the first edges after release
  always_comb up_d = {up_q[0], 1'b1};
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      up_q <= 2'h0;
    end else begin
      up_q <= up_d;
    end
  end
  // settings that may only move while the bus is clocking
  assign cfg = {mic_amp_en_o, out_amp_en_o, tx_gain_db_o, sidetone_db_o, tone_freq_a_o};
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);
  a_mic_onehot: assert property (up_q[1] |-> $onehot0(mic_amp_en_o))
    else $error("mic enables not one-hot");
  a_out_onehot: assert property (up_q[1] |-> $onehot0(out_amp_en_o))
    else $error("output amp enables not one-hot");
  a_switch_excl: assert property (up_q[1] |-> switch_a_conn_o != switch_c_conn_o)
    else $error("switch pins not exclusive");
  a_tx_tone_ref: assert property (up_q[1] |-> tx_tone_lvl_b_o == tx_gain_db_o - 7'sd14 &&
    tx_tone_lvl_a_o == tx_gain_db_o - (tone_dtmf_o ? 7'sd16 : 7'sd14))
    else $error("transmit tone level wrong");
  a_rx_tone_ref: assert property (up_q[1] && !rx_tone_mute_o |->
    rx_tone_lvl_a_o == rx_tone_db_o + (tone_dtmf_o ? 7'sd4 : 7'sd6))
    else $error("receive tone level wrong");
  a_ext_tone_on: assert property (ext_tone_en_o == (tone_gen_en_o && !rx_tone_mute_o))
    else $error("external tone enable wrong");
  a_dtmf_pair: assert property (tone_dtmf_o |-> tone_valid_o &&
    tone_freq_a_o inside {12'h2b9, 12'h302, 12'h354, 12'h3ad} &&
    tone_freq_b_o inside {12'h4b9, 12'h538, 12'h5c5, 12'h661})
    else $error("dtmf pair outside the grid");
  a_side_range: assert property (sidetone_en_o |-> sidetone_db_o >= -7'sd15 && sidetone_db_o <= -7'sd3)
    else $error("side-tone gain out of range");
  a_tone_range: assert property (!rx_tone_mute_o |->
    rx_tone_db_o >= -7'sd34 && rx_tone_db_o <= -7'sd6 && !rx_tone_db_o[0])
    else $error("tone gain out of range");
  a_regs_hold: assert property ($stable(scl_i) [*8] |=> $stable(cfg))
    else $error("setting moved without bus traffic");
  c_dtmf_send: cover property (tone_dtmf_o && tone_send_o);
  c_tone_out: cover property (ext_tone_en_o);
  c_no_mic: cover property (up_q[1] && mic_amp_en_o == 3'h0);
endmodule // cpt_regs_assertions

bind cpt_regs cpt_regs_assertions cpt_regs_assertions_inst (
  .clk_sys_i, .rst_n_i, .scl_i, .mic_amp_en_o, .out_amp_en_o, .switch_a_conn_o, .switch_c_conn_o,
  .tx_gain_db_o, .sidetone_en_o, .sidetone_db_o, .tone_gen_en_o, .rx_tone_mute_o, .rx_tone_db_o,
  .ext_tone_en_o, .tone_dtmf_o, .tone_send_o, .tx_tone_lvl_a_o, .tx_tone_lvl_b_o, .rx_tone_lvl_a_o,
  .tone_freq_a_o, .tone_freq_b_o, .tone_valid_o
);

//--- verif/cpt_mcu_model.sv
`timescale 1ns/1ps
module cpt_mcu_model #(
  parameter logic [6:0] ADDR = 7'h2a, // arbitrary, matches the device default
  parameter int H = 8
) (
  input wire logic clk_sys_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_pull_o
);
  // idle: both lines released, the pull-up holds them high
  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  // data moves only mid-low, so it is steady for the whole high phase
  task automatic bt(input logic b, output logic r);
    scl_o <= 1'b0;
    wt(H);
    sda_pull_o <= ~b;
    wt(H);
    scl_o <= 1'b1;
    wt(H);
    r = sda_i;
    wt(H);
  endtask
  // start when stp is 0, stop when 1: data edge while the clock is high
  task automatic go(input logic stp);
    scl_o <= 1'b0;
    wt(H);
    sda_pull_o <= stp;
    wt(H);
    scl_o <= 1'b1;
    wt(2 * H);
    sda_pull_o <= ~stp;
    wt(2 * H);
  endtask
  // eight bits msb first, then the acknowledge slot with the line released
  task automatic by(input logic [7:0] d, output logic [7:0] q, output logic ak);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bt(d[i], r);
      q[i] = r;
    end
    bt(1'b1, r);
    ak = ~r;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d, output logic ak);
    logic [7:0] q;
    logic k;
    go(1'b0);
    by({a, 1'b0}, q, ak);
    by(p, q, k);
    by(d, q, k);
    go(1'b1);
  endtask
  // single-byte read ends with a nack so the device lets go of the line
  task automatic rd(input logic [7:0] p, output logic [7:0] q);
    logic k;
    go(1'b0);
    by({ADDR, 1'b0}, q, k);
    by(p, q, k);
    go(1'b0);
    by({ADDR, 1'b1}, q, k);
    by(8'hff, q, k);
    go(1'b1);
  endtask
endmodule // cpt_mcu_model

//--- verif/cpt_regs_tb.sv
`timescale 1ns/1ps
module cpt_regs_tb;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic scl_i, pull, ak, sda_o, sda_oe_o;
  wire sda_i;
  logic [2:0] mic_amp_en_o, out_amp_en_o;
  logic short_frame_o, switch_a_conn_o, switch_c_conn_o, rx_pad_en_o, tx_pcm_en_o, rx_pcm_en_o;
  logic sidetone_en_o, tone_gen_en_o, rx_tone_mute_o, ext_tone_en_o, tone_dtmf_o, tone_send_o;
  logic tone_warble_o, tone_valid_o;
  logic signed [6:0] tx_gain_db_o, rx_gain_db_o, sidetone_db_o, rx_tone_db_o;
  logic signed [6:0] tx_tone_lvl_a_o, tx_tone_lvl_b_o, rx_tone_lvl_a_o, rx_tone_lvl_b_o;
  logic [11:0] tone_freq_a_o, tone_freq_b_o;
  logic [7:0] q, v;
  int error_cnt = 0;
  int checks = 0;
  localparam logic [11:0] FLO [4] = '{12'h2b9, 12'h302, 12'h354, 12'h3ad};
  localparam logic [11:0] FHI [4] = '{12'h4b9, 12'h538, 12'h5c5, 12'h661};
  // other tones: code, freq a, freq b, warble, valid
  localparam logic [11:0] OT [5][5] = '{'{12'h000, 12'haaa, 12'h9c4, 12'h001, 12'h001},
    '{12'h009, 12'h190, 12'h190, 12'h000, 12'h001}, '{12'h00a, 12'h1b8, 12'h1b8, 12'h000, 12'h001},
    '{12'h01f, 12'hbb8, 12'hbb8, 12'h000, 12'h001}, '{12'h003, 12'h000, 12'h000, 12'h000, 12'h000}};
  // open drain: low when either side pulls, otherwise the pull-up wins
  assign sda_i = (sda_oe_o ? sda_o : 1'b1) & ~pull;
  cpt_regs cpt_regs_inst (.clk_sys_i, .rst_n_i, .scl_i, .sda_i, .sda_o, .sda_oe_o, .mic_amp_en_o,
    .out_amp_en_o, .short_frame_o, .switch_a_conn_o, .switch_c_conn_o, .rx_pad_en_o, .tx_pcm_en_o,
    .rx_pcm_en_o, .tx_gain_db_o, .rx_gain_db_o, .sidetone_en_o, .sidetone_db_o, .tone_gen_en_o,
    .rx_tone_mute_o, .rx_tone_db_o, .ext_tone_en_o, .tone_dtmf_o, .tone_send_o, .tx_tone_lvl_a_o,
    .tx_tone_lvl_b_o, .rx_tone_lvl_a_o, .rx_tone_lvl_b_o, .tone_freq_a_o, .tone_freq_b_o,
    .tone_warble_o, .tone_valid_o);
  cpt_mcu_model cpt_mcu_model_inst (.clk_sys_i, .sda_i, .scl_o(scl_i), .sda_pull_o(pull));
  // 20 MHz system clock
  initial begin
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(input logic signed [31:0] got, input logic signed [31:0] want);
    checks++;
    if (got !== want) begin
      error_cnt++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, want);
    end
  endtask
  task automatic close_out();
    if (error_cnt == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic w(input logic [7:0] p, input logic [7:0] d);
    cpt_mcu_model_inst.wr(7'h2a, p, d, ak);
    chk(ak, 1);
  endtask
  task automatic rst_pulse();
    rst_n_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (5) @(posedge clk_sys_i);
  endtask
  // a full run is about 50k cycles; a hang is cut off at 90k cycles, well above that
  initial begin
    repeat (90000) @(posedge clk_sys_i);
    error_cnt++;
    close_out();
  end
  // main sequence: reset values, then each register field by field
  initial begin
    rst_pulse();
    chk({mic_amp_en_o, tx_pcm_en_o, rx_pcm_en_o, sidetone_en_o, rx_tone_mute_o}, 7'h1d);
    chk(tx_gain_db_o, 0);
    chk(rx_gain_db_o, -3);
    for (int r = 1; r <= 4; r++) begin
      cpt_mcu_model_inst.rd(r[7:0], q);
      chk(q, r == 2 ? 8'h33 : 8'h00);
    end
    // reserved bit 2 written as one on purpose
    for (int k = 0; k < 4; k++) begin
      v = {k[1:0], k[1:0], k[0], 1'b1, k[1], k[0]};
      w(cpt_pkg::OFS_PATH, v);
      chk(mic_amp_en_o, k == 3 ? 0 : 1 << k);
      chk(out_amp_en_o, k == 3 ? 0 : 1 << k);
      chk({short_frame_o, switch_a_conn_o, switch_c_conn_o, rx_pad_en_o}, {k[0], ~k[1], k[1], k[0]});
      chk(rx_gain_db_o, k[0] ? -15 : -3);
      cpt_mcu_model_inst.rd(cpt_pkg::OFS_PATH, q);
      chk(q, v & 8'hfb);
    end
    // pad stays in, so receive gain is 12 dB down
    for (int k = 0; k < 8; k++) begin
      w(cpt_pkg::OFS_PCM, {k[0], k[2:0], k[1], k[2:0]});
      chk({tx_pcm_en_o, rx_pcm_en_o}, {~k[0], ~k[1]});
      chk(tx_gain_db_o, -6 + 2 * k);
      chk(rx_gain_db_o, -24 + 3 * k);
      chk(tx_tone_lvl_b_o, -20 + 2 * k);
    end
    for (int k = 0; k < 16; k++) begin
      w(cpt_pkg::OFS_TGAIN, {k[2:0], k[0], k[3:0]});
      chk({sidetone_en_o, sidetone_db_o}, {k[2:0] != 0, 7'(-17 + 2 * k[2:0])});
      chk({tone_gen_en_o, rx_tone_mute_o, ext_tone_en_o}, {k[0], k == 0, k[0]});
      chk(rx_tone_db_o, -36 + 2 * k);
      chk(rx_tone_lvl_b_o, -30 + 2 * k);
    end
    // reserved bit 5 set and ignored bit 4 toggled on purpose
    for (int k = 0; k < 16; k += 5) begin
      v = {1'b1, k[0], 1'b1, ~k[0], k[3:0]};
      w(cpt_pkg::OFS_TMODE, v);
      chk({tone_dtmf_o, tone_send_o}, {1'b1, k[0]});
      chk(tone_freq_a_o, FLO[k[3:2]]);
      chk(tone_freq_b_o, FHI[k[1:0]]);
      chk(tx_tone_lvl_a_o, -8);
      chk(rx_tone_lvl_a_o, -2);
    end
    cpt_mcu_model_inst.rd(cpt_pkg::OFS_TMODE, q);
    chk(q, v & 8'hdf);
    for (int i = 0; i < 5; i++) begin
      w(cpt_pkg::OFS_TMODE, 8'(OT[i][0]));
      chk({tone_dtmf_o, tone_warble_o, tone_valid_o}, {1'b0, OT[i][3][0], OT[i][4][0]});
      chk({tone_freq_a_o, tone_freq_b_o}, {OT[i][1], OT[i][2]});
      chk({tx_tone_lvl_a_o, rx_tone_lvl_a_o}, {-7'sd6, 7'sd0});
    end
    // unmapped pointer and foreign address leave the settings alone
    w(8'h05, 8'h5a);
    cpt_mcu_model_inst.rd(8'h05, q);
    chk(q, 0);
    cpt_mcu_model_inst.wr(7'h2b, cpt_pkg::OFS_PCM, 8'h00, ak);
    chk({ak, tx_gain_db_o}, 8'h08);
    rst_pulse();
    chk({mic_amp_en_o, out_amp_en_o, tone_dtmf_o}, 7'h12);
    chk(rx_gain_db_o, -3);
    close_out();
  end
endmodule // cpt_regs_tb
